// ### rtl/qpl_pkg.sv
// Purpose : Shared constants and types for the quadrature position latch.
// Assumes : 100 MHz system clock, synchronous active-low reset.
// Notes   : Filter times are given in ns and turned into clock counts here.
package qpl_pkg;

   // -------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------
   localparam int CNT_W   = 24;  // Width of position counter and latch.
   localparam int NUM_CH  = 5;   // Encoder channels, one latch each.

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam longint unsigned CLK_HZ      = 64'd100_000_000;
   localparam longint unsigned NS_PER_S    = 64'd1_000_000_000;
   localparam longint unsigned MAX_LINE_HZ = 64'd250_000;
   // Shortest spacing of two A/B edges at the highest line rate.
   localparam longint unsigned MIN_EDGE_NS = NS_PER_S / (4 * MAX_LINE_HZ);
   localparam int MIN_EDGE_CYC =
      int'((MIN_EDGE_NS * CLK_HZ) / NS_PER_S);
   // Encoder glitch filter, kept well under the shortest edge spacing.
   localparam longint unsigned ENC_FILT_NS  = 64'd200;
   localparam int ENC_FILT_CYC =
      int'((ENC_FILT_NS * CLK_HZ) / NS_PER_S);
   // Fast input filter, shorter than that of a general DC input.
   localparam longint unsigned FAST_FILT_NS = 64'd2_000;
   localparam int FAST_FILT_CYC =
      int'((FAST_FILT_NS * CLK_HZ) / NS_PER_S);
   localparam longint unsigned DC_FILT_NS   = 64'd5_000_000;
   localparam int DC_FILT_CYC =
      int'((DC_FILT_NS * CLK_HZ) / NS_PER_S);

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   // Capture trigger selection.
   typedef enum logic [1:0] {
      QPL_TRIG_OFF   = 2'h0,
      QPL_TRIG_INDEX = 2'h1,
      QPL_TRIG_FAST  = 2'h2,
      QPL_TRIG_ARMED = 2'h3
   } qpl_trig_e;

   // Per-channel configuration.
   typedef struct packed {
      qpl_trig_e trig;       // Capture trigger source.
      logic      fast_fall;  // 1 selects falling fast-input edge.
   } qpl_cfg_s;

   // Per-channel status.
   typedef struct packed {
      logic armed;     // Fast edge seen, waiting for index.
      logic cap_flag;  // Sticky: a capture happened.
      logic err_flag;  // Sticky: A and B changed together.
      logic wrap_flag; // Sticky: counter wrapped.
   } qpl_stat_s;

endpackage

// ### rtl/qpl_in_filt.sv
// Purpose : Synchronise one input and pass it on once it has been stable.
// Assumes : FILT_CYC is at least one.
// Notes   : Adds two sync cycles plus FILT_CYC cycles of delay.
`timescale 1ns/1ps
`default_nettype none
module qpl_in_filt #(
   parameter int FILT_CYC = 20
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic raw_in,
   output logic      level_out
);
   localparam int CW = $clog2(FILT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

   logic          sync1_ff;
   logic          sync2_ff;
   logic [CW-1:0] stab_ff;

   // Two-stage synchroniser; only the second stage reads the first.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Count how long the new level has held, then accept it.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         stab_ff   <= '0;
         level_out <= 1'b0;
      end else if (sync2_ff == level_out) begin
         stab_ff <= '0;
      end else if (stab_ff == LAST) begin
         stab_ff   <= '0;
         level_out <= sync2_ff;
      end else begin
         stab_ff <= stab_ff + CW'(1);
      end
   end
endmodule // qpl_in_filt
`default_nettype wire

// ### rtl/qpl_quad_dec.sv
// Purpose : Decode filtered A/B into an up/down position count.
// Assumes : A and B are already synchronous and filtered.
// Notes   : Counts every edge of A and B; a double change is an error.
`timescale 1ns/1ps
`default_nettype none
module qpl_quad_dec
   import qpl_pkg::*;
#(
   parameter int CW = CNT_W
) (
   input  wire logic          clk_in,
   input  wire logic          resetn_in,
   input  wire logic          a_in,
   input  wire logic          b_in,
   input  wire logic          clr_in,
   output logic [CW-1:0]      cnt_out,
   output logic               err_out,
   output logic               wrap_out
);
   logic [1:0] prev_ff;
   logic       init_ff;
   logic [1:0] cur_ph;
   logic [1:0] step;

   // Phase number: 00,10,11,01 run 0..3 when A leads B.
   assign cur_ph = {b_in, a_in ^ b_in};
   assign step   = cur_ph - prev_ff;

   // Remember the last phase; the first cycle after reset only loads it.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         prev_ff <= 2'h0;
         init_ff <= 1'b0;
      end else begin
         prev_ff <= cur_ph;
         init_ff <= 1'b1;
      end
   end

   // Up on +1 phase, down on -1 phase, wrap modulo 2**CW.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cnt_out  <= CW'(CNT_RST);
         err_out  <= 1'b0;
         wrap_out <= 1'b0;
      end else begin
         err_out  <= init_ff && (step == 2'h2);
         wrap_out <= 1'b0;
         if (clr_in) begin
            cnt_out <= CW'(CNT_RST);
         end else if (init_ff && step == 2'h1) begin
            cnt_out  <= cnt_out + CW'(1);
            wrap_out <= &cnt_out;
         end else if (init_ff && step == 2'h3) begin
            cnt_out  <= cnt_out - CW'(1);
            wrap_out <= ~|cnt_out;
         end
      end
   end
endmodule // qpl_quad_dec
`default_nettype wire

// ### rtl/qpl_top.sv
// Purpose : Multi-channel encoder counter with hardware position latch.
// Assumes : Pins are synchronous to clk_in; no software register bus.
// Notes   : Each channel counts quadrature edges and can latch its count
//           on index, on a fast-input edge, or on index after that edge.
//           Every output comes straight from a flip-flop.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each channel owns a 24-bit up/down counter.
// - Every A and B edge moves count by one.
// - Count direction follows A/B phase order.
// - Each channel owns a 24-bit capture register.
// - Index mode captures on each index pulse.
// - Fast mode captures on chosen fast-input edge.
// - Armed mode: fast edge, then next index.
// - Five latches, each with own fast input.
// - Counts correctly up to maximum encoder line rate.
// - Capture happens in hardware at trigger time.
// - Fast inputs filtered less than DC inputs.
module qpl_top
   import qpl_pkg::*;
#(
   parameter int NCH       = NUM_CH,
   parameter int CW        = CNT_W,
   parameter int ENC_FILT  = ENC_FILT_CYC,
   parameter int FAST_FILT = FAST_FILT_CYC
) (
   input  wire logic                      clk_in,
   input  wire logic                      resetn_in,
   input  wire logic     [NCH-1:0]        enc_a_in,
   input  wire logic     [NCH-1:0]        enc_b_in,
   input  wire logic     [NCH-1:0]        enc_idx_in,
   input  wire logic     [NCH-1:0]        fast_in,
   input  wire qpl_cfg_s [NCH-1:0]        cfg_in,
   input  wire logic     [NCH-1:0]        cnt_clr_in,
   input  wire logic     [NCH-1:0]        flag_clr_in,
   output logic          [NCH-1:0][CW-1:0] pos_out,
   output logic          [NCH-1:0][CW-1:0] latch_out,
   output qpl_stat_s     [NCH-1:0]        stat_out,
   output logic          [NCH-1:0]        cap_pulse_out
);

   // ------------------------------------------------------------------
   // Build-time checks on the filter lengths
   // ------------------------------------------------------------------
   // The encoder filter must settle well inside the shortest edge gap,
   // otherwise an edge at full line rate could be swallowed.
   localparam bit ENC_FILT_OK  = (ENC_FILT < MIN_EDGE_CYC);
   // The fast inputs must react faster than a general DC input would.
   localparam bit FAST_FILT_OK = (FAST_FILT < DC_FILT_CYC);

   // Refuse to build with a filter that cannot settle in time; such a
   // block would drop edges with no sign of it at the outputs.
   generate
      if (!ENC_FILT_OK || !FAST_FILT_OK || ENC_FILT < 1 || FAST_FILT < 1)
      begin : g_bad_filt
         $error("qpl_top: filter length out of range");
      end
   endgenerate

   // ------------------------------------------------------------------
   // Capture state machine codes
   // ------------------------------------------------------------------
   // Gray order: idle, waiting for fast edge, waiting for index.
   // Each step along the usual path flips a single bit.
   // Code 2'h2 is unused; the default arm sends it back to idle.
   typedef enum logic [1:0] {
      CAP_IDLE     = 2'h0,
      CAP_WAIT_FST = 2'h1,
      CAP_WAIT_IDX = 2'h3
   } qpl_cap_e;

   // ------------------------------------------------------------------
   // One slice per channel
   // ------------------------------------------------------------------
   // Channels share only the clock and the reset.
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         logic          a_f;
         logic          b_f;
         logic          idx_f;
         logic          fst_f;
         logic          idx_prev_ff;
         logic          fst_prev_ff;
         logic          idx_rise;
         logic          fst_edge;
         logic [CW-1:0] cnt;
         logic          dec_err;
         logic          dec_wrap;
         qpl_cap_e      cap_st_ff;
         qpl_cap_e      nxt_cap_st;
         logic          trig_hit;
         qpl_trig_e     mode_ff;

         // ---------------------------------------------------------------
         // Input conditioning
         // ---------------------------------------------------------------
         // No edge logic looks at a raw pin: each one passes two
         // flops and then waits for a level that has stayed put.
         // Synchronise and glitch-filter the encoder lines.
         qpl_in_filt #(
            .FILT_CYC (ENC_FILT)
         ) u_a_filt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .raw_in    (enc_a_in[ch]),
            .level_out (a_f)
         );

         qpl_in_filt #(
            .FILT_CYC (ENC_FILT)
         ) u_b_filt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .raw_in    (enc_b_in[ch]),
            .level_out (b_f)
         );

         qpl_in_filt #(
            .FILT_CYC (ENC_FILT)
         ) u_idx_filt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .raw_in    (enc_idx_in[ch]),
            .level_out (idx_f)
         );

         // The dedicated fast input of this latch uses the short filter.
         qpl_in_filt #(
            .FILT_CYC (FAST_FILT)
         ) u_fst_filt (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .raw_in    (fast_in[ch]),
            .level_out (fst_f)
         );

         // Edge history of index and fast input.
         // Both start low like the filters, so no false edge follows
         // reset unless a line really is high.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               idx_prev_ff <= 1'b0;
               fst_prev_ff <= 1'b0;
            end else begin
               idx_prev_ff <= idx_f;
               fst_prev_ff <= fst_f;
            end
         end

         // Index pulse start, and the fast edge chosen by configuration.
         // Only the rising edge of index counts as the pulse.
         // The fast edge polarity is the channel's own setting.
         assign idx_rise = idx_f & ~idx_prev_ff;
         assign fst_edge = cfg_in[ch].fast_fall ?
                           (~fst_f & fst_prev_ff) :
                           (fst_f & ~fst_prev_ff);

         // ---------------------------------------------------------------
         // Position counter
         // ---------------------------------------------------------------
         // Decoder owns the per-channel up/down count.
         // A clear wins over a step in the same cycle.
         // It also reports lost steps and wraps.
         qpl_quad_dec #(
            .CW (CW)
         ) u_dec (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .a_in      (a_f),
            .b_in      (b_f),
            .clr_in    (cnt_clr_in[ch]),
            .cnt_out   (cnt),
            .err_out   (dec_err),
            .wrap_out  (dec_wrap)
         );

         // Registered copy of the count for the outputs.
         // It trails the count by one cycle, so it equals the
         // latched value while cap_pulse_out is high.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               pos_out[ch] <= CW'(CNT_RST);
            end else begin
               pos_out[ch] <= cnt;
            end
         end

         // ---------------------------------------------------------------
         // Capture control
         // ---------------------------------------------------------------
         // Track the mode so that a change restarts the sequence.
         // The restart takes one cycle; an edge in that cycle is
         // ignored on purpose.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               mode_ff <= QPL_TRIG_OFF;
            end else begin
               mode_ff <= cfg_in[ch].trig;
            end
         end

         // Next state and trigger decision for the selected mode.
         // Armed mode needs a fresh fast edge after each capture; an
         // index pulse before that edge is ignored. State and trigger
         // are decided together so that latch and flags agree.
         always_comb begin
            nxt_cap_st = cap_st_ff;
            trig_hit   = 1'b0;
            if (cfg_in[ch].trig != mode_ff) begin
               nxt_cap_st = CAP_IDLE;
            end else begin
               unique case (cap_st_ff)
                  CAP_IDLE: begin
                     if (cfg_in[ch].trig == QPL_TRIG_INDEX) begin
                        trig_hit = idx_rise;
                     end else if (cfg_in[ch].trig == QPL_TRIG_FAST) begin
                        trig_hit = fst_edge;
                     end else if (cfg_in[ch].trig == QPL_TRIG_ARMED) begin
                        nxt_cap_st = CAP_WAIT_FST;
                     end
                  end
                  CAP_WAIT_FST: begin
                     if (fst_edge) begin
                        nxt_cap_st = CAP_WAIT_IDX;
                     end
                  end
                  CAP_WAIT_IDX: begin
                     if (idx_rise) begin
                        trig_hit   = 1'b1;
                        nxt_cap_st = CAP_WAIT_FST;
                     end
                  end
                  default: begin
                     nxt_cap_st = CAP_IDLE;
                  end
               endcase
            end
         end

         // Capture sequence state.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               cap_st_ff <= CAP_IDLE;
            end else begin
               cap_st_ff <= nxt_cap_st;
            end
         end

         // Latch the live count the cycle the trigger is seen.
         // The counter itself is taken, not pos_out, so no output
         // stage adds delay between trigger and capture.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               latch_out[ch]     <= CW'(CNT_RST);
               cap_pulse_out[ch] <= 1'b0;
            end else begin
               cap_pulse_out[ch] <= trig_hit;
               if (trig_hit) begin
                  latch_out[ch] <= cnt;
               end
            end
         end

         // ---------------------------------------------------------------
         // Status
         // ---------------------------------------------------------------
         // Armed shows that the fast edge has been taken in armed mode.
         // It follows the next state so it rises with the state.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               stat_out[ch].armed <= 1'b0;
            end else begin
               stat_out[ch].armed <= (nxt_cap_st == CAP_WAIT_IDX);
            end
         end

         // Sticky flags; a new event in the clearing cycle wins.
         // Error marks a lost step (A and B moved in one sample);
         // wrap marks a pass through zero.
         always_ff @(posedge clk_in) begin
            if (!resetn_in) begin
               stat_out[ch].cap_flag  <= 1'b0;
               stat_out[ch].err_flag  <= 1'b0;
               stat_out[ch].wrap_flag <= 1'b0;
            end else begin
               stat_out[ch].cap_flag  <= trig_hit |
                  (stat_out[ch].cap_flag & ~flag_clr_in[ch]);
               stat_out[ch].err_flag  <= dec_err |
                  (stat_out[ch].err_flag & ~flag_clr_in[ch]);
               stat_out[ch].wrap_flag <= dec_wrap |
                  (stat_out[ch].wrap_flag & ~flag_clr_in[ch]);
            end
         end
      end
   endgenerate

endmodule // qpl_top
`default_nettype wire

// ### tb/qpl_monitor.sv
// Purpose : Port-level checks for the position latch, one set per channel.
// Assumes : One clock, synchronous active-low reset.
// Notes   : Bound into every qpl_top instance.
`timescale 1ns/1ps
`default_nettype none
module qpl_monitor
   import qpl_pkg::*;
#(
   parameter int NCH = NUM_CH,
   parameter int CW  = CNT_W
) (
   input wire logic                      clk_in,
   input wire logic                      resetn_in,
   input wire qpl_cfg_s  [NCH-1:0]         cfg_in,
   input wire logic      [NCH-1:0]         cnt_clr_in,
   input wire logic      [NCH-1:0]         flag_clr_in,
   input wire logic      [NCH-1:0][CW-1:0] pos_out,
   input wire logic      [NCH-1:0][CW-1:0] latch_out,
   input wire qpl_stat_s [NCH-1:0]         stat_out,
   input wire logic      [NCH-1:0]         cap_pulse_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   // -------------------------------------------------------------------
   // Per-channel checks
   // -------------------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // A latch never moves without its capture pulse.
      latch_pulse_a:
         assert property ($changed(latch_out[i]) |-> cap_pulse_out[i])
         else $error("latch moved without a capture pulse");
      pulse_once_a:
         assert property (cap_pulse_out[i] |=> !cap_pulse_out[i])
         else $error("capture pulse longer than one cycle");
      flag_set_a:
         assert property (cap_pulse_out[i] |-> stat_out[i].cap_flag)
         else $error("capture flag not set by a capture");
      latch_value_a:
         assert property (cap_pulse_out[i] |-> latch_out[i] == pos_out[i])
         else $error("latched value differs from the count");
      flag_clear_a:
         assert property (flag_clr_in[i] ##1 !cap_pulse_out[i]
                          |-> !stat_out[i].cap_flag)
         else $error("capture flag survived its clear");
      off_quiet_a:
         assert property ((cfg_in[i].trig == QPL_TRIG_OFF) [*3]
                          |=> !cap_pulse_out[i])
         else $error("capture while trigger is off");
      armed_idle_a:
         assert property ((cfg_in[i].trig != QPL_TRIG_ARMED) [*3]
                          |-> !stat_out[i].armed)
         else $error("armed status outside armed mode");
      // The count moves by no more than one per cycle unless cleared.
      pos_step_a:
         assert property ($changed(pos_out[i]) && !$past(cnt_clr_in[i])
                          && !$past(cnt_clr_in[i], 2)
                          |-> CW'(pos_out[i] - $past(pos_out[i]))
                              inside {CW'(1), {CW{1'b1}}})
         else $error("count moved by more than one");
      reset_zero_a:
         assert property ($rose(resetn_in) |-> pos_out[i] == '0
                          && latch_out[i] == '0 && stat_out[i] == '0
                          && !cap_pulse_out[i])
         else $error("outputs not cleared by reset");
   end
endmodule // qpl_monitor

bind qpl_top qpl_monitor #(.NCH(NCH), .CW(CW)) u_mon (
   .clk_in        (clk_in),
   .resetn_in     (resetn_in),
   .cfg_in        (cfg_in),
   .cnt_clr_in    (cnt_clr_in),
   .flag_clr_in   (flag_clr_in),
   .pos_out       (pos_out),
   .latch_out     (latch_out),
   .stat_out      (stat_out),
   .cap_pulse_out (cap_pulse_out)
);
`default_nettype wire

// ### tb/qpl_enc_model.sv
// Purpose : Behavioural quadrature encoder with index and fast reference.
// Assumes : Lines change 1 ns after a rising clock edge.
// Notes   : Steps are GAP+1 cycles apart to stay inside the line rate.
`timescale 1ns/1ps
`default_nettype none
module qpl_enc_model #(
   parameter int NCH = 5,
   parameter int GAP = 100
) (
   input  wire logic           clk_in,
   output logic     [NCH-1:0]  a_out,
   output logic     [NCH-1:0]  b_out,
   output logic     [NCH-1:0]  idx_out,
   output logic     [NCH-1:0]  fast_out
);
   // -------------------------------------------------------------------
   // Shaft state
   // -------------------------------------------------------------------
   int ph [NCH];

   // All lines start low with every shaft at phase zero.
   initial begin
      a_out    = '0;
      b_out    = '0;
      idx_out  = '0;
      fast_out = '0;
   end

   // One quarter-line step; moving up makes A lead B.
   task automatic step(input int ch, input bit up);
      ph[ch] = (ph[ch] + (up ? 1 : 3)) % 4;
      @(posedge clk_in);
      #1;
      a_out[ch] = (ph[ch] == 1) || (ph[ch] == 2);
      b_out[ch] = (ph[ch] >= 2);
      repeat (GAP) @(posedge clk_in);
      #1;
   endtask

   // Two quarter steps at once: A and B change together.
   task automatic jump(input int ch);
      ph[ch] = (ph[ch] + 1) % 4;
      step(ch, 1'b1);
   endtask

   // Index and fast lines change just after the next edge and keep the new level.
   task automatic idx(input int ch, input bit v);
      @(posedge clk_in);
      #1;
      idx_out[ch] = v;
   endtask

   task automatic fast(input int ch, input bit v);
      @(posedge clk_in);
      #1;
      fast_out[ch] = v;
   endtask
endmodule // qpl_enc_model
`default_nettype wire

// ### tb/qpl_tb.sv
// Purpose : Self-checking bench for the quadrature position latch.
// Assumes : Short filters (2 and 4 cycles) to keep the run brief.
// Notes   : Inputs change 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qpl_pkg::*;
   localparam int NCH = 5;
   localparam int EF  = 2;
   localparam int FF  = 4;

   logic                       clk_in = 1'b0;
   logic                       resetn_in = 1'b0;
   logic      [NCH-1:0]          enc_a, enc_b, enc_idx, fast;
   qpl_cfg_s  [NCH-1:0]          cfg;
   logic      [NCH-1:0]          cnt_clr, flag_clr, cap;
   logic      [NCH-1:0][CNT_W-1:0] pos, latch;
   qpl_stat_s [NCH-1:0]          stat;
   int                         err_total = 0;
   int                         check_count = 0;

   // Free-running 100 MHz clock.
   always #5 clk_in = ~clk_in;

   qpl_enc_model #(.NCH(NCH)) u_enc (
      .clk_in   (clk_in),
      .a_out    (enc_a),
      .b_out    (enc_b),
      .idx_out  (enc_idx),
      .fast_out (fast)
   );

   qpl_top #(.NCH(NCH), .ENC_FILT(EF), .FAST_FILT(FF)) u_dut (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .enc_a_in      (enc_a),
      .enc_b_in      (enc_b),
      .enc_idx_in    (enc_idx),
      .fast_in       (fast),
      .cfg_in        (cfg),
      .cnt_clr_in    (cnt_clr),
      .flag_clr_in   (flag_clr),
      .pos_out       (pos),
      .latch_out     (latch),
      .stat_out      (stat),
      .cap_pulse_out (cap)
   );

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // Clears the sticky flags of one channel.
   task automatic clr_flag(input int c);
      flag_clr[c] = 1'b1;
      tick(1);
      flag_clr[c] = 1'b0;
   endtask

   // Waits for a capture, then checks its delay and the stored value.
   task automatic wait_cap(input int c, input int lat, input int val);
      int n;
      n = 0;
      while (cap[c] !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      if (n == 60) begin
         err_total++;
         end_of_test();
      end
      chk(CNT_W'(n), CNT_W'(lat));
      chk(latch[c], CNT_W'(val));
   endtask

   // A full index pulse that is expected to be ignored.
   task automatic idx_pulse(input int c);
      clr_flag(c);
      u_enc.idx(c, 1'b1);
      tick(EF + 8);
      u_enc.idx(c, 1'b0);
      tick(EF + 8);
      chk(CNT_W'(stat[c].cap_flag), 24'h000000);
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_count();
      for (int k = 0; k < 8; k++) u_enc.step(0, 1'b1);
      chk(pos[0], 24'h000008);
      chk(pos[1], 24'h000000);
      for (int k = 0; k < 10; k++) u_enc.step(0, 1'b0);
      chk(pos[0], 24'hfffffe);
      chk(CNT_W'(stat[0].wrap_flag), 24'h000001);
      u_enc.jump(4);
      chk(CNT_W'(stat[4].err_flag), 24'h000001);
      chk(pos[4], 24'h000000);
      idx_pulse(2);
      cnt_clr[0] = 1'b1;
      tick(1);
      cnt_clr[0] = 1'b0;
      tick(3);
      chk(pos[0], 24'h000000);
   endtask

   task automatic t_index();
      for (int c = 0; c < NCH; c++) begin
         cfg[c].trig = QPL_TRIG_INDEX;
         for (int k = 0; k <= c; k++) u_enc.step(c, 1'b1);
         u_enc.idx(c, 1'b1);
         wait_cap(c, EF + 3, c + 1);
         chk(CNT_W'(stat[c].cap_flag), 24'h000001);
         clr_flag(c);
         chk(CNT_W'(stat[c].cap_flag), 24'h000000);
         u_enc.idx(c, 1'b0);
      end
   endtask

   // Selected fast edge captures; the other edge must not.
   task automatic t_fast();
      chk(CNT_W'(FAST_FILT_CYC < DC_FILT_CYC), 24'h000001);
      for (int c = 0; c < NCH; c++) begin
         cfg[c].trig = QPL_TRIG_FAST;
         cfg[c].fast_fall = c[0];
         tick(3);
         for (int v = 1; v >= 0; v--) begin
            clr_flag(c);
            u_enc.fast(c, v[0]);
            if (v[0] ^ c[0]) begin
               wait_cap(c, FF + 3, c + 1);
            end else begin
               tick(FF + 8);
               chk(CNT_W'(stat[c].cap_flag), 24'h000000);
            end
         end
      end
   endtask

   task automatic t_armed();
      cfg[3].trig = QPL_TRIG_ARMED;
      cfg[3].fast_fall = 1'b0;
      tick(3);
      idx_pulse(3);
      u_enc.fast(3, 1'b1);
      tick(FF + 8);
      chk(CNT_W'(stat[3].armed), 24'h000001);
      u_enc.step(3, 1'b1);
      u_enc.step(3, 1'b1);
      u_enc.idx(3, 1'b1);
      wait_cap(3, EF + 3, 6);
      u_enc.idx(3, 1'b0);
      tick(EF + 8);
      idx_pulse(3);
   endtask

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      cfg = '0;
      cnt_clr = '0;
      flag_clr = '0;
      repeat (10) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      t_count();
      t_index();
      t_fast();
      t_armed();
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
